// ==== hdl/esw_regs.vh ====
// Opcodes, field positions and reset values of the status register bank
`ifndef ESW_REGS_VH
`define ESW_REGS_VH

// ==========================================================
// Serial commands that this bank acts on
`define ESW_OP_WRSR       8'h01
`define ESW_OP_WR         8'h02
`define ESW_OP_WRDI       8'h04
`define ESW_OP_RDSR       8'h05
`define ESW_OP_SET_WRITE_LATCH_CMD       8'h06
`define ESW_OP_WRSR2      8'h31
`define ESW_OP_PERS       8'h42
`define ESW_OP_CERS_A     8'h60
`define ESW_OP_CERS_B     8'hc7
`define ESW_OP_PD         8'hb9

// ==========================================================
// Byte one field positions
`define ESW_B1_BUSY       0
`define ESW_B1_LATCH      1
`define ESW_B1_GUARD_LO   2
`define ESW_B1_GUARD_HI   3
`define ESW_B1_SLEEP_IND  4
`define ESW_B1_LOW_STBY   5
`define ESW_B1_IDLE_SLEEP 6
`define ESW_B1_LOCK       7

// ==========================================================
// Byte two field positions
`define ESW_B2_SLEEP_AW   0
`define ESW_B2_SLOW_OSC   1

// ==========================================================
// Reset values and frame lengths
`define ESW_NV_RESET      4'h0
`define ESW_LOCK_RESET    1'b0
`define ESW_B2_RESET      2'h0
`define ESW_BITS_CMD      5'h08
`define ESW_BITS_CMD_DATA 5'h10
`define ESW_SYNC_STAGES   2

`endif

// ==== hdl/esw_rx.v ====
// Serial receiver: bit counter, command byte and last data byte
`timescale 1ns/1ps
`include "esw_regs.vh"

module esw_rx (
   // Clock and reset
   input  wire       clk_sys,
   input  wire       reset,
   // Synchronised serial inputs and edge strobe
   input  wire       frame_on,
   input  wire       sck_rise,
   input  wire       sdi_s,
   // Frame state
   output reg  [4:0] bit_count,
   output reg        long_frame,
   output reg  [7:0] command,
   output reg  [7:0] data_byte
);

   reg [7:0] shift;
   wire [7:0] next_shift;

   assign next_shift = {shift[6:0], sdi_s};

   // ==========================================================
   // Shift in on each rising serial clock inside a frame
   always @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         bit_count  <= 5'h00;
         long_frame <= 1'b0;
         shift      <= 8'h00;
         command    <= 8'h00;
         data_byte  <= 8'h00;
      end else if (!frame_on) begin
         bit_count  <= 5'h00;
         long_frame <= 1'b0;
      end else if (sck_rise) begin
         shift     <= next_shift;
         bit_count <= bit_count + 5'h01;
         if (bit_count == 5'h1f)
            long_frame <= 1'b1;           // Wrapped, too long for a status write; whole-byte write-class frames still act
         if (bit_count == 5'h07 && !long_frame)
            command <= next_shift;
         if (bit_count[2:0] == 3'h7)
            data_byte <= next_shift;
      end
   end

endmodule // esw_rx

// ==== hdl/esw_status.v ====
// Status and configuration bytes with write protection
//
// Overview of operation
// - Two status bytes, readable any time, even during a self-timed write.
// - Byte one bit 0 is the read-only busy flag of program or erase.
// - Byte one bit 1 is the volatile write latch; 1 means writes enabled.
// - Byte one bits 2 and 3 are non-volatile block guard bits.
// - Byte one bit 4 reads 1 in deep sleep, else 0.
// - Byte one bit 5 enables low-power standby when idle.
// - Byte one bit 6 selects power-down instead of standby when idle.
// - Status lock set and protect pin low rejects byte one writes.
// - Byte two bit 0 sends the device to deep sleep after an array write or a byte one write.
// - Byte two bit 1 slows the oscillator during self-timed writes.
// - Byte two bits 2 to 7 are reserved and read zero.
// - Status writes only act when select rises after the exact bit count; other writes need whole bytes.
// - Write-class commands are ignored while the write latch is clear.
// - The write latch is clear after power-up.
`timescale 1ns/1ps
`include "esw_regs.vh"

module esw_status (
   // Clock and reset
   input  wire       clk_sys,
   input  wire       reset,
   // Serial pins
   input  wire       cs_n,
   input  wire       sck,
   input  wire       sdi,
   input  wire       wp_n,
   output reg        sdo,
   output reg        sdo_oe,
   // Device state from the write timer and power logic
   input  wire       write_busy,
   input  wire       deep_sleep,
   // Configuration towards the rest of the device
   output wire       busy_flag,
   output reg        write_latch,
   output reg        block_guard_lo,
   output reg        block_guard_hi,
   output wire       deep_sleep_indicator,
   output reg        low_standby_enable,
   output reg        idle_sleep_enable,
   output reg        status_lock,
   output reg        sleep_after_write,
   output reg        slow_osc_during_write,
   // Events towards the write timer and power logic
   output reg        nv_store_start,
   output reg        sleep_request,
   output wire       slow_osc_active
);

   // ==========================================================
   // Pin synchronisation and edge finding
   wire [3:0] pins_s;
   wire       cs_n_s;
   wire       sck_s;
   wire       sdi_s;
   wire       wp_n_s;
   reg        sck_d;
   reg        cs_n_d;
   reg        busy_d;
   wire       sck_rise;
   wire       sck_fall;
   wire       frame_end;
   wire       busy_end;

   esw_sync #(
      .WIDTH    (4)
   ) u_sync (
      .clk_sys  (clk_sys),
      .reset    (reset),
      .pin_in   ({cs_n, sck, sdi, wp_n}),
      .pin_sync (pins_s)
   );

   assign cs_n_s    = pins_s[3];
   assign sck_s     = pins_s[2];
   assign sdi_s     = pins_s[1];
   assign wp_n_s    = pins_s[0];
   assign sck_rise  = sck_s & ~sck_d;
   assign sck_fall  = ~sck_s & sck_d;
   assign frame_end = cs_n_s & ~cs_n_d;
   assign busy_end  = busy_d & ~write_busy;

   // Delayed copies for edge detection
   // Reset levels match the synchroniser, so no rise follows reset
   always @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         sck_d  <= 1'b1;
         cs_n_d <= 1'b1;
         busy_d <= 1'b0;
      end else begin
         sck_d  <= sck_s;
         cs_n_d <= cs_n_s;
         busy_d <= write_busy;
      end
   end

   // ==========================================================
   // Serial receiver
   // Bit count at select rise decides whether a write is exact
   wire [4:0] bit_count;
   wire       long_frame;
   wire [7:0] command;
   wire [7:0] data_byte;

   esw_rx u_rx (
      .clk_sys    (clk_sys),
      .reset      (reset),
      .frame_on   (~cs_n_s),
      .sck_rise   (sck_rise),
      .sdi_s      (sdi_s),
      .bit_count  (bit_count),
      .long_frame (long_frame),
      .command    (command),
      .data_byte  (data_byte)
   );

   // ==========================================================
   // Status byte images
   wire [7:0] status_one;
   wire [7:0] status_two;

   assign busy_flag            = write_busy;
   assign deep_sleep_indicator = deep_sleep;
   assign status_one = {status_lock,                       // Bit 7
                        idle_sleep_enable,                 // Bit 6
                        low_standby_enable,                // Bit 5
                        deep_sleep_indicator,
                        block_guard_hi,                    // Bit 3
                        block_guard_lo,                    // Bit 2
                        write_latch,                       // Bit 1
                        busy_flag};                        // Bit 0
   assign status_two = {6'h00,
                        slow_osc_during_write,
                        sleep_after_write};

   // ==========================================================
   // Frame qualification at the rising edge of select
   // A cut frame never reaches an action, so it changes nothing
   wire exact_cmd;
   wire exact_cmd_data;
   wire whole_bytes;
   wire status_open;
   reg  is_write_class;
   reg  is_array_write;
   wire do_set_write_latch_cmd;
   wire do_wrdi;
   wire do_wrsr;
   wire do_wrsr2;
   wire do_other;

   assign exact_cmd      = ~long_frame &
                           (bit_count == `ESW_BITS_CMD);
   assign exact_cmd_data = ~long_frame &
                           (bit_count == `ESW_BITS_CMD_DATA);
   assign whole_bytes    = (long_frame | (bit_count != 5'h00)) &
                           (bit_count[2:0] == 3'h0);
   // Protect pin high, or lock clear, leaves the bytes writable
   assign status_open    = ~status_lock | wp_n_s;

   // Opcodes whose completion clears the latch; array writes arm sleep
   always @* begin
      is_write_class = 1'b0;
      is_array_write = 1'b0;
      case (command)
         `ESW_OP_WR: begin
            is_write_class = 1'b1;
            is_array_write = 1'b1;
         end
         `ESW_OP_PERS: begin
            is_write_class = 1'b1;
         end
         `ESW_OP_CERS_A: begin
            is_write_class = 1'b1;
         end
         `ESW_OP_CERS_B: begin
            is_write_class = 1'b1;
         end
         `ESW_OP_PD: begin
            is_write_class = 1'b1;
         end
         default: begin
            is_write_class = 1'b0;
            is_array_write = 1'b0;
         end
      endcase
   end

   // Each action fires once, on the cycle select is seen rising
   assign do_set_write_latch_cmd  = frame_end & exact_cmd &
                     (command == `ESW_OP_SET_WRITE_LATCH_CMD);
   assign do_wrdi  = frame_end & exact_cmd &
                     (command == `ESW_OP_WRDI);
   assign do_wrsr  = frame_end & exact_cmd_data &
                     (command == `ESW_OP_WRSR) &
                     write_latch & status_open &
                     ~write_busy;
   assign do_wrsr2 = frame_end & exact_cmd_data &
                     (command == `ESW_OP_WRSR2) &
                     write_latch & ~write_busy;
   assign do_other = frame_end & whole_bytes &
                     is_write_class & write_latch;

   // ==========================================================
   // Write latch: set by enable, cleared by any completed write
   // A refused or cut write leaves the latch as it was
   always @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         write_latch <= 1'b0;
      end else if (do_set_write_latch_cmd) begin
         write_latch <= 1'b1;
      end else if (do_wrdi | do_wrsr | do_wrsr2 | do_other) begin
         write_latch <= 1'b0;
      end
   end

   // ==========================================================
   // Non-volatile fields of byte one; busy and sleep untouched
   always @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         {idle_sleep_enable, low_standby_enable,
          block_guard_hi, block_guard_lo} <= `ESW_NV_RESET;
         status_lock <= `ESW_LOCK_RESET;
      end else if (do_wrsr) begin
         block_guard_lo     <= data_byte[`ESW_B1_GUARD_LO];
         block_guard_hi     <= data_byte[`ESW_B1_GUARD_HI];
         low_standby_enable <= data_byte[`ESW_B1_LOW_STBY];
         idle_sleep_enable  <= data_byte[`ESW_B1_IDLE_SLEEP];
         status_lock        <= data_byte[`ESW_B1_LOCK];
      end
   end

   // ==========================================================
   // Volatile fields of byte two
   // Byte two ignores the lock; only latch and busy gate it
   always @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         {slow_osc_during_write, sleep_after_write} <= `ESW_B2_RESET;
      end else if (do_wrsr2) begin
         sleep_after_write     <= data_byte[`ESW_B2_SLEEP_AW];
         slow_osc_during_write <= data_byte[`ESW_B2_SLOW_OSC];
      end
   end

   // Slowing is only in force while a write runs
   assign slow_osc_active = slow_osc_during_write & write_busy;

   // ==========================================================
   // Event pulses: nv store start and sleep after a write
   // Store pulse lets the write timer begin the non-volatile update
   reg sleep_armed;

   always @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         nv_store_start <= 1'b0;
         sleep_request  <= 1'b0;
         sleep_armed    <= 1'b0;
      end else begin
         nv_store_start <= do_wrsr;
         sleep_request  <= busy_end & sleep_armed &
                           sleep_after_write;
         // Only array writes and byte one writes arm the sleep
         if (do_wrsr | (do_other & is_array_write))
            sleep_armed <= 1'b1;
         else if (busy_end)
            sleep_armed <= 1'b0;
      end
   end

   // ==========================================================
   // Status read: byte one then byte two, repeating
   // Live images: a change during a read shows from the next bit
   wire       reading;
   wire [7:0] read_byte;
   wire [2:0] bit_sel;

   assign reading   = ~cs_n_s & (long_frame | bit_count >= 5'h08) &
                      (command == `ESW_OP_RDSR);
   assign read_byte = bit_count[3] ? status_one : status_two;
   assign bit_sel   = 3'h7 - bit_count[2:0];

   // Output enable from the first data fall until deselect
   always @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         sdo_oe <= 1'b0;
      end else if (cs_n_s) begin
         sdo_oe <= 1'b0;
      end else if (sck_fall && reading) begin
         sdo_oe <= 1'b1;
      end
   end

   // Data change on the falling serial clock, live values
   always @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         sdo <= 1'b0;
      end else if (sck_fall && reading) begin
         sdo <= read_byte[bit_sel];
      end
   end

endmodule // esw_status

// ==== hdl/esw_sync.v ====
// Two-stage synchroniser for a group of pin inputs
`timescale 1ns/1ps

module esw_sync #(
   parameter WIDTH = 4
) (
   // Clock and reset
   input  wire             clk_sys,
   input  wire             reset,
   // Pin side and synchronised side
   input  wire [WIDTH-1:0] pin_in,
   output wire [WIDTH-1:0] pin_sync
);

   genvar i;

   // ==========================================================
   // One flop pair per bit; stage one feeds only stage two
   generate
      for (i = 0; i < WIDTH; i = i + 1) begin : g_bit
         reg stage_one;
         reg stage_two;
         always @(posedge clk_sys or posedge reset) begin
            if (reset) begin
               stage_one <= 1'b1;
               stage_two <= 1'b1;
            end else begin
               stage_one <= pin_in[i];
               stage_two <= stage_one;
            end
         end
         assign pin_sync[i] = stage_two;
      end
   endgenerate

endmodule // esw_sync

// ==== sim/eeprom_status_write_protect_bench.sv ====
// Testbench of the status bank, frames sent by the host model
`timescale 1ns/1ps
`include "esw_regs.vh"

module eeprom_status_write_protect_bench;
   reg         clk_sys, reset, wp_n, write_busy, deep_sleep;
   wire        cs_n, sck, sdi, sdo, sdo_oe, busy_flag, write_latch;
   wire        block_guard_lo, block_guard_hi, deep_sleep_indicator;
   wire        low_standby_enable, idle_sleep_enable, status_lock;
   wire        sleep_after_write, slow_osc_during_write;
   wire        nv_store_start, sleep_request, slow_osc_active;
   int         mismatches, compares, k;
   reg  [23:0] rx;
   reg  [7:0]  b1, b2;

   esw_status u_dut (.clk_sys(clk_sys), .reset(reset), .cs_n(cs_n),
      .sck(sck), .sdi(sdi), .wp_n(wp_n), .sdo(sdo), .sdo_oe(sdo_oe),
      .write_busy(write_busy), .deep_sleep(deep_sleep),
      .busy_flag(busy_flag), .write_latch(write_latch),
      .block_guard_lo(block_guard_lo), .block_guard_hi(block_guard_hi),
      .deep_sleep_indicator(deep_sleep_indicator),
      .low_standby_enable(low_standby_enable),
      .idle_sleep_enable(idle_sleep_enable), .status_lock(status_lock),
      .sleep_after_write(sleep_after_write),
      .slow_osc_during_write(slow_osc_during_write),
      .nv_store_start(nv_store_start), .sleep_request(sleep_request),
      .slow_osc_active(slow_osc_active));

   esw_spi_host u_host (.clk_sys(clk_sys), .sdo(sdo), .sdo_oe(sdo_oe),
      .cs_n(cs_n), .sck(sck), .sdi(sdi));

   // 25 MHz system clock
   initial begin
      clk_sys = 1'b0;
      forever #20 clk_sys = ~clk_sys;
   end

   // Compare and count
   task automatic check(input string what, input [7:0] exp,
                        input [7:0] got);
      compares++;
      if (got !== exp) begin
         mismatches++;
         $display("[FAIL] %s expected %h seen %h", what, exp, got);
      end
   endtask

   // Command frame, write frame with data, status read
   task automatic cmd(input [7:0] op, input int n);
      u_host.frame({op, 16'h0000}, n, rx);
   endtask
   task automatic wr(input [7:0] op, input [7:0] d, input int n);
      u_host.frame({op, d, 8'h00}, n, rx);
   endtask
   task automatic rdsr;
      u_host.frame({`ESW_OP_RDSR, 16'h0000}, 24, rx);
      b1 = rx[15:8];
      b2 = rx[7:0];
   endtask

   // Verdict and end of run
   task automatic conclude;
      $display("compares %0d mismatches %0d", compares, mismatches);
      if (mismatches == 0 && compares > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask

   // Hang guard
   initial begin
      repeat (60000) @(posedge clk_sys);
      mismatches++;
      conclude;
   end

   // Main sequence
   initial begin
      mismatches = 0;
      compares = 0;
      reset = 1'b1;
      wp_n = 1'b1;
      write_busy = 1'b0;
      deep_sleep = 1'b0;
      repeat (12) @(posedge clk_sys);
      reset <= 1'b0;
      repeat (4) @(posedge clk_sys);
      check("latch", 8'h00, {7'h00, write_latch});
      rdsr;
      check("byte1", 8'h00, b1);
      check("byte2", 8'h00, b2);
      $display("test reset done");
      wr(`ESW_OP_WRSR, 8'h0c, 16);
      rdsr;
      check("byte1 no latch", 8'h00, b1);
      cmd(`ESW_OP_SET_WRITE_LATCH_CMD, 7);
      check("latch short", 8'h00, {7'h00, write_latch});
      cmd(`ESW_OP_SET_WRITE_LATCH_CMD, 8);
      check("latch set", 8'h01, {7'h00, write_latch});
      wr(`ESW_OP_WRSR, 8'h0c, 17);
      rdsr;
      check("byte1 long", 8'h02, b1);
      cmd(`ESW_OP_WRDI, 8);
      check("latch off", 8'h00, {7'h00, write_latch});
      cmd(`ESW_OP_SET_WRITE_LATCH_CMD, 8);
      cmd(`ESW_OP_CERS_B, 12);
      check("latch cut erase", 8'h01, {7'h00, write_latch});
      cmd(`ESW_OP_CERS_B, 8);
      check("latch chip erase", 8'h00, {7'h00, write_latch});
      cmd(`ESW_OP_SET_WRITE_LATCH_CMD, 8);
      cmd(`ESW_OP_PERS, 24);
      check("latch page erase", 8'h00, {7'h00, write_latch});
      cmd(`ESW_OP_SET_WRITE_LATCH_CMD, 8);
      cmd(`ESW_OP_CERS_A, 8);
      check("latch erase alt", 8'h00, {7'h00, write_latch});
      cmd(`ESW_OP_SET_WRITE_LATCH_CMD, 8);
      cmd(`ESW_OP_PD, 8);
      check("latch power down", 8'h00, {7'h00, write_latch});
      cmd(`ESW_OP_SET_WRITE_LATCH_CMD, 8);
      cmd(`ESW_OP_WR, 24);
      check("latch array write", 8'h00, {7'h00, write_latch});
      $display("test gating done");
      cmd(`ESW_OP_SET_WRITE_LATCH_CMD, 8);
      wr(`ESW_OP_WRSR, 8'hff, 16);
      rdsr;
      check("byte1 all", 8'hec, b1);
      cmd(`ESW_OP_SET_WRITE_LATCH_CMD, 8);
      wr(`ESW_OP_WRSR2, 8'hff, 16);
      rdsr;
      check("byte2 all", 8'h03, b2);
      $display("test fields done");
      for (k = 0; k < 4; k++) begin
         cmd(`ESW_OP_SET_WRITE_LATCH_CMD, 8);
         wr(`ESW_OP_WRSR, {k[1], 7'h00}, 16);
         wp_n <= k[0];
         cmd(`ESW_OP_SET_WRITE_LATCH_CMD, 8);
         wr(`ESW_OP_WRSR, 8'h0c, 16);
         rdsr;
         check("lock", (k == 2) ? 8'h82 : 8'h0c, b1);
         wp_n <= 1'b1;
      end
      $display("test lock done");
      write_busy <= 1'b1;
      deep_sleep <= 1'b1;
      cmd(`ESW_OP_SET_WRITE_LATCH_CMD, 8);
      wr(`ESW_OP_WRSR, 8'h00, 16);
      rdsr;
      check("byte1 busy", 8'h1f, b1);
      check("slow osc", 8'h01, {7'h00, slow_osc_active});
      write_busy <= 1'b0;
      deep_sleep <= 1'b0;
      cmd(`ESW_OP_SET_WRITE_LATCH_CMD, 8);
      wr(`ESW_OP_WRSR, 8'h00, 16);
      write_busy <= 1'b1;
      repeat (20) @(posedge clk_sys);
      write_busy <= 1'b0;
      for (k = 0; k < 10 && sleep_request !== 1'b1; k++)
         @(negedge clk_sys);
      check("sleep req", 8'h01, {7'h00, sleep_request});
      $display("test busy done");
      conclude;
   end
endmodule // eeprom_status_write_protect_bench

// ==== sim/esw_spi_host.sv ====
// Serial host model driving mode 0 frames into the status bank
`timescale 1ns/1ps

module esw_spi_host (
   // Clock
   input  wire clk_sys,
   // Serial pins
   input  wire sdo,
   input  wire sdo_oe,
   output reg  cs_n,
   output reg  sck,
   output reg  sdi
);
   reg  last_sdo = 1'b0;
   wire miso;

   // Released line shows the inverse of its last value
   assign miso = sdo_oe ? sdo : ~last_sdo;

   // Idle pins, clock stands low between frames
   initial begin
      cs_n = 1'b1;
      sck = 1'b0;
      sdi = 1'b0;
   end

   // Remember the last driven output bit
   always @(posedge clk_sys) begin
      if (sdo_oe)
         last_sdo <= sdo;
   end

   // One frame of n bits, MSB first; sdo taken at end of each high phase
   task automatic frame(input [23:0] tx, input int n, output [23:0] rx);
      int i;
      rx = 24'h000000;
      cs_n <= 1'b0;
      repeat (4) @(posedge clk_sys);
      for (i = 0; i < n; i++) begin
         sdi <= tx[23-i];
         repeat (4) @(posedge clk_sys);
         sck <= 1'b1;
         repeat (4) @(posedge clk_sys);
         rx = {rx[22:0], miso};
         sck <= 1'b0;
      end
      repeat (4) @(posedge clk_sys);
      cs_n <= 1'b1;
      repeat (12) @(posedge clk_sys);
   endtask
endmodule // esw_spi_host

// ==== sim/esw_status_chk.sv ====
// Concurrent checks on the ports of the status bank
`timescale 1ns/1ps

module esw_status_chk (
   // Clock and reset
   input wire clk_sys,
   input wire reset,
   // Pins and device state
   input wire cs_n,
   input wire wp_n,
   input wire sdo_oe,
   input wire write_busy,
   input wire deep_sleep,
   // Configuration and events
   input wire busy_flag,
   input wire write_latch,
   input wire block_guard_lo,
   input wire block_guard_hi,
   input wire deep_sleep_indicator,
   input wire low_standby_enable,
   input wire idle_sleep_enable,
   input wire status_lock,
   input wire sleep_after_write,
   input wire slow_osc_during_write,
   input wire nv_store_start,
   input wire sleep_request,
   input wire slow_osc_active
);
   wire [6:0] cfg;

   // All host-writable fields in one vector
   assign cfg = {status_lock, idle_sleep_enable, low_standby_enable,
                 block_guard_hi, block_guard_lo, sleep_after_write,
                 slow_osc_during_write};

   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (reset);

   // Deselected for a while; end of a self-timed write
   sequence s_idle6; cs_n [*6]; endsequence
   sequence s_write_end; write_busy ##1 !write_busy; endsequence

   a_busy_mirror: assert property (busy_flag == write_busy)
      else $error("busy flag differs from write timer");
   a_ind_mirror: assert property (deep_sleep_indicator == deep_sleep)
      else $error("sleep indicator differs from power state");
   a_slow_gate: assert property
      (slow_osc_active == (slow_osc_during_write && write_busy))
      else $error("slow oscillator request wrong");
   a_store_once: assert property (nv_store_start |=> !nv_store_start)
      else $error("store pulse longer than one cycle");
   a_store_latch: assert property
      (nv_store_start |-> $past(write_latch, 2) && !write_latch)
      else $error("store without prior write latch");
   a_cfg_latch: assert property ($changed(cfg) |-> $past(write_latch))
      else $error("field changed with latch clear");
   a_cfg_lock: assert property
      ($changed(cfg) |-> !($past(status_lock) && !$past(wp_n)))
      else $error("field changed while locked");
   a_cfg_frame: assert property
      ($changed(cfg) |-> cs_n && $past(cs_n, 2))
      else $error("field changed inside a frame");
   a_latch_set: assert property
      ($rose(write_latch) |-> cs_n && $past(cs_n, 2))
      else $error("latch set inside a frame");
   a_sleep_src: assert property
      (sleep_request |-> $past(write_busy, 2) && !$past(write_busy))
      else $error("sleep request not after write end");
   a_sdo_quiet: assert property (s_idle6 |-> !sdo_oe)
      else $error("output driven while deselected");

   c_sleep: cover property (s_write_end ##1 sleep_request);
endmodule // esw_status_chk

bind esw_status esw_status_chk u_chk (.clk_sys, .reset, .cs_n, .wp_n,
   .sdo_oe, .write_busy, .deep_sleep, .busy_flag, .write_latch,
   .block_guard_lo, .block_guard_hi, .deep_sleep_indicator,
   .low_standby_enable, .idle_sleep_enable, .status_lock,
   .sleep_after_write, .slow_osc_during_write, .nv_store_start,
   .sleep_request, .slow_osc_active);
